//--- common/cpa_defines.svh
`ifndef CPA_DEFINES_SVH
`define CPA_DEFINES_SVH

// ****************************************
// move-instruction encodings
// ****************************************
`define CPA_ACC_OPC1 3'h0
`define CPA_ACC_CRN  4'h1
`define CPA_ACC_CRM  4'h0
`define CPA_ACC_OPC2 3'h2
`define CPA_SEC_OPC1 3'h0
`define CPA_SEC_CRN  4'h1
`define CPA_SEC_CRM  4'h1
`define CPA_SEC_OPC2 3'h0

// ****************************************
// field positions
// ****************************************
`define CPA_SIMD_DIS_BIT  31
`define CPA_UPPER_DIS_BIT 30
`define CPA_HIGH_MSB      23
`define CPA_HIGH_LSB      22
`define CPA_LOW_MSB       21
`define CPA_LOW_LSB       20
`define CPA_GATE_LOW_BIT  0
`define CPA_GATE_HIGH_BIT 1
`define CPA_SEC_MSB       5

// ****************************************
// reset values
// ****************************************
`define CPA_PERM_RESET 2'h0
`define CPA_DIS_RESET  1'h0
`define CPA_SEC_RESET  6'h00
`define CPA_WORD_ZERO  32'h0000_0000

`endif

//--- common/cpa_pkg.sv
package cpa_pkg;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    CPA_PERM_DENY = 2'b00,
    CPA_PERM_PRIV = 2'b01,
    CPA_PERM_RSVD = 2'b10,
    CPA_PERM_ALL  = 2'b11
  } cpa_perm_e;

  typedef enum logic [1:0] {
    CPA_BUILD_FP_SIMD = 2'b00,
    CPA_BUILD_FP_ONLY = 2'b01,
    CPA_BUILD_NONE    = 2'b10
  } cpa_build_e;

  typedef struct packed {
    logic        simd_dis;
    logic        upper_dis;
    logic [1:0]  perm_high;
    logic [1:0]  perm_low;
    logic [5:0]  sec_cfg;
    logic [31:0] rdata;
    logic        ack;
    logic        undef;
  } cpa_regs_s;

  typedef struct packed {
    logic done;
    logic undef;
  } cpa_gate_s;

  // permission decode; reserved code grants nothing
  function automatic logic cpa_perm_allows(input logic [1:0] perm, input logic priv);
    unique case (perm)
      CPA_PERM_PRIV: cpa_perm_allows = priv;
      CPA_PERM_ALL:  cpa_perm_allows = 1'b1;
      default:       cpa_perm_allows = 1'b0;
    endcase
  endfunction : cpa_perm_allows

endpackage : cpa_pkg

//--- hdl/cpa_access_check.sv
`timescale 1ns/10ps
`include "cpa_defines.svh"

module cpa_access_check (
  // move-instruction encoding
  input  wire logic [2:0] opc1,
  input  wire logic [3:0] crn,
  input  wire logic [3:0] crm,
  input  wire logic [2:0] opc2,
  // issuing context
  input  wire logic       privileged,
  input  wire logic       nonsecure,
  // decode result
  output logic            hit_acc,
  output logic            hit_sec,
  output logic            refuse
);

  function automatic logic enc_match(input logic [2:0] o1, input logic [3:0] n,
                                     input logic [3:0] m, input logic [2:0] o2);
    enc_match = (opc1 == o1) && (crn == n) && (crm == m) && (opc2 == o2);
  endfunction : enc_match

  // ****************************************
  // decode
  // ****************************************
  // access register encoding
  assign hit_acc = enc_match(`CPA_ACC_OPC1, `CPA_ACC_CRN, `CPA_ACC_CRM, `CPA_ACC_OPC2);
  // secure configuration decoded in every build
  assign hit_sec = enc_match(`CPA_SEC_OPC1, `CPA_SEC_CRN, `CPA_SEC_CRM, `CPA_SEC_OPC2);

  // user access refused secure config only secure privileged
  assign refuse = (hit_acc && !privileged) ||
                  (hit_sec && (!privileged || nonsecure));

endmodule : cpa_access_check

//--- hdl/cpa_instr_gate.sv
`timescale 1ns/10ps
`include "cpa_defines.svh"

module cpa_instr_gate (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // coprocessor instruction from decode
  input  wire logic       ins_valid,
  input  wire logic       ins_cp_high,
  input  wire logic       ins_simd,
  input  wire logic       ins_upper_dregs,
  input  wire logic       ins_privileged,
  input  wire logic       ins_nonsecure,
  // current rights
  input  wire logic [1:0] perm_low,
  input  wire logic [1:0] perm_high,
  input  wire logic       simd_dis,
  input  wire logic       upper_dis,
  input  wire logic [1:0] ns_gate,
  // verdict
  output logic            ins_done,
  output logic            ins_undef
);

  cpa_pkg::cpa_gate_s st_q;
  cpa_pkg::cpa_gate_s st_d;
  logic [1:0]         perm;
  logic               gate_ok;
  logic               deny;

  // ****************************************
  // verdict
  // ****************************************
  always_comb begin
    // simd uses the low field; both fields are kept equal by software
    perm    = (ins_simd || !ins_cp_high) ? perm_low : perm_high;
    // non-secure use also needs the gate
    gate_ok = !ins_nonsecure ||
              (ins_simd ? (ns_gate[`CPA_GATE_LOW_BIT] && ns_gate[`CPA_GATE_HIGH_BIT])
                        : ns_gate[ins_cp_high]);
    deny    = !cpa_pkg::cpa_perm_allows(perm, ins_privileged) ||
              (ins_simd && simd_dis) ||
              (!ins_simd && ins_upper_dregs && upper_dis) ||
              !gate_ok;
    st_d       = st_q;
    st_d.done  = ins_valid;
    st_d.undef = ins_valid && deny;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign ins_done  = st_q.done;
  assign ins_undef = st_q.undef;

  // ****************************************
  // checks
  // ****************************************
  property p_simd_undef;
    @(posedge core_clk) disable iff (rst)
      ins_valid && ins_simd && simd_dis |=> ins_done && ins_undef;
  endproperty
  a_simd_undef: assert property (p_simd_undef) else $error("simd not refused");

  property p_upper_undef;
    @(posedge core_clk) disable iff (rst)
      ins_valid && !ins_simd && ins_upper_dregs && upper_dis |=> ins_undef;
  endproperty
  a_upper_undef: assert property (p_upper_undef) else $error("upper regs not refused");

  property p_deny_undef;
    @(posedge core_clk) disable iff (rst)
      ins_valid && !ins_cp_high && perm_low == 2'h0 |=> ins_undef;
  endproperty
  a_deny_undef: assert property (p_deny_undef) else $error("denied cp ran");

  property p_ns_gate;
    @(posedge core_clk) disable iff (rst)
      ins_valid && ins_nonsecure && !ins_simd && !ns_gate[ins_cp_high] |=> ins_undef;
  endproperty
  a_ns_gate: assert property (p_ns_gate) else $error("gate ignored");

endmodule : cpa_instr_gate

//--- hdl/cpa_regs.sv
`timescale 1ns/10ps
`include "cpa_defines.svh"

module cpa_regs #(
  parameter cpa_pkg::cpa_build_e BUILD = cpa_pkg::CPA_BUILD_FP_SIMD
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // system-register move port
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic [2:0]  req_opc1,
  input  wire logic [3:0]  req_crn,
  input  wire logic [3:0]  req_crm,
  input  wire logic [2:0]  req_opc2,
  input  wire logic [31:0] req_wdata,
  input  wire logic        req_privileged,
  input  wire logic        req_nonsecure,
  // move answer
  output logic             resp_valid,
  output logic             resp_undef,
  output logic [31:0]      resp_rdata,
  // non-secure gate bits
  input  wire logic [1:0]  nonsecure_access_gate,
  // coprocessor instruction check
  input  wire logic        ins_valid,
  input  wire logic        ins_cp_high,
  input  wire logic        ins_simd,
  input  wire logic        ins_upper_dregs,
  input  wire logic        ins_privileged,
  input  wire logic        ins_nonsecure,
  output logic             ins_done,
  output logic             ins_undef,
  // current settings
  output logic             simd_disable,
  output logic             upper_dregs_disable,
  output logic [1:0]       fp_pair_high_permission,
  output logic [1:0]       fp_pair_low_permission,
  output logic [5:0]       secure_configuration
);

  // ****************************************
  // build constants
  // ****************************************
  localparam logic FP_PRESENT = (BUILD != cpa_pkg::CPA_BUILD_NONE);
  localparam logic FP_ONLY    = (BUILD == cpa_pkg::CPA_BUILD_FP_ONLY);

  cpa_pkg::cpa_regs_s st_q;
  cpa_pkg::cpa_regs_s st_d;
  logic               hit_acc;
  logic               hit_sec;
  logic               refuse;
  logic               do_write;
  logic               eff_simd;
  logic               eff_upper;

  // ****************************************
  // decode
  // ****************************************
  cpa_access_check u_check (
    .opc1       (req_opc1),
    .crn        (req_crn),
    .crm        (req_crm),
    .opc2       (req_opc2),
    .privileged (req_privileged),
    .nonsecure  (req_nonsecure),
    .hit_acc    (hit_acc),
    .hit_sec    (hit_sec),
    .refuse     (refuse)
  );

  // ****************************************
  // helpers
  // ****************************************
  // field visible and writable from this context
  function automatic logic field_open(input logic ns, input logic gate);
    field_open = !ns || gate;
  endfunction : field_open

  // next value of one permission field
  function automatic logic [1:0] perm_next(input logic [1:0] cur, input logic [1:0] wr,
                                           input logic open);
    if (!FP_PRESENT) begin
      perm_next = `CPA_PERM_RESET;
    end else if (open) begin
      perm_next = wr;
    end else begin
      perm_next = cur;
    end
  endfunction : perm_next

  // ****************************************
  // effective disable bits
  // ****************************************
  always_comb begin
    if (FP_ONLY) begin
      eff_simd  = 1'b1;
      eff_upper = 1'b1;
    end else begin
      eff_simd  = st_q.simd_dis;
      eff_upper = st_q.upper_dis;
    end
  end

  // ****************************************
  // next state
  // ****************************************
  assign do_write = req_valid && req_write && !refuse;

  always_comb begin
    st_d       = st_q;
    st_d.ack   = req_valid && (hit_acc || hit_sec);
    st_d.undef = req_valid && refuse;
    st_d.rdata = `CPA_WORD_ZERO;
    // single copy, no banking on security state
    if (do_write && hit_acc) begin
      if (BUILD == cpa_pkg::CPA_BUILD_FP_SIMD) begin
        st_d.simd_dis  = req_wdata[`CPA_SIMD_DIS_BIT];
        st_d.upper_dis = req_wdata[`CPA_UPPER_DIS_BIT];
      end
      st_d.perm_high = perm_next(st_q.perm_high,
                                 req_wdata[`CPA_HIGH_MSB:`CPA_HIGH_LSB],
                                 field_open(req_nonsecure,
                                            nonsecure_access_gate[`CPA_GATE_HIGH_BIT]));
      st_d.perm_low  = perm_next(st_q.perm_low,
                                 req_wdata[`CPA_LOW_MSB:`CPA_LOW_LSB],
                                 field_open(req_nonsecure,
                                            nonsecure_access_gate[`CPA_GATE_LOW_BIT]));
    end
    if (do_write && hit_sec) begin
      st_d.sec_cfg = req_wdata[`CPA_SEC_MSB:0];
    end
    if (req_valid && !req_write && !refuse && hit_acc) begin
      if (FP_PRESENT) begin
        st_d.rdata[`CPA_SIMD_DIS_BIT]  = eff_simd;
        st_d.rdata[`CPA_UPPER_DIS_BIT] = eff_upper;
      end
      if (field_open(req_nonsecure, nonsecure_access_gate[`CPA_GATE_HIGH_BIT])) begin
        st_d.rdata[`CPA_HIGH_MSB:`CPA_HIGH_LSB] = st_q.perm_high;
      end
      if (field_open(req_nonsecure, nonsecure_access_gate[`CPA_GATE_LOW_BIT])) begin
        st_d.rdata[`CPA_LOW_MSB:`CPA_LOW_LSB] = st_q.perm_low;
      end
    end
    if (req_valid && !req_write && !refuse && hit_sec) begin
      st_d.rdata[`CPA_SEC_MSB:0] = st_q.sec_cfg;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q.simd_dis  <= `CPA_DIS_RESET;
      st_q.upper_dis <= `CPA_DIS_RESET;
      st_q.perm_high <= `CPA_PERM_RESET;
      st_q.perm_low  <= `CPA_PERM_RESET;
      st_q.sec_cfg   <= `CPA_SEC_RESET;
      st_q.rdata     <= `CPA_WORD_ZERO;
      st_q.ack       <= 1'b0;
      st_q.undef     <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign resp_valid              = st_q.ack || st_q.undef;
  assign resp_undef              = st_q.undef;
  assign resp_rdata              = st_q.rdata;
  assign simd_disable            = eff_simd;
  assign upper_dregs_disable     = eff_upper;
  assign fp_pair_high_permission = st_q.perm_high;
  assign fp_pair_low_permission  = st_q.perm_low;
  assign secure_configuration    = st_q.sec_cfg;

  // ****************************************
  // instruction gate
  // ****************************************
  cpa_instr_gate u_gate (
    .core_clk        (core_clk),
    .rst             (rst),
    .ins_valid       (ins_valid),
    .ins_cp_high     (ins_cp_high),
    .ins_simd        (ins_simd),
    .ins_upper_dregs (ins_upper_dregs),
    .ins_privileged  (ins_privileged),
    .ins_nonsecure   (ins_nonsecure),
    .perm_low        (st_q.perm_low),
    .perm_high       (st_q.perm_high),
    .simd_dis        (eff_simd),
    .upper_dis       (eff_upper),
    .ns_gate         (nonsecure_access_gate),
    .ins_done        (ins_done),
    .ins_undef       (ins_undef)
  );

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_acc_req;
    req_valid && req_opc1 == 3'h0 && req_crn == 4'h1 && req_crm == 4'h0 && req_opc2 == 3'h2;
  endsequence

  sequence s_sec_req;
    req_valid && req_opc1 == 3'h0 && req_crn == 4'h1 && req_crm == 4'h1 && req_opc2 == 3'h0;
  endsequence

  property p_user_undef;
    s_acc_req ##0 !req_privileged |=> resp_valid && resp_undef;
  endproperty
  a_user_undef: assert property (p_user_undef) else $error("user access not refused");

  property p_user_no_write;
    s_acc_req ##0 !req_privileged ##0 req_write |=> $stable(fp_pair_low_permission);
  endproperty
  a_user_no_write: assert property (p_user_no_write) else $error("user write took");

  // must stay live while reset is high
  property p_reset_perm;
    @(posedge core_clk) disable iff (1'b0)
      rst |=> fp_pair_low_permission == 2'h0 && fp_pair_high_permission == 2'h0;
  endproperty
  a_reset_perm: assert property (p_reset_perm) else $error("permission reset wrong");

  property p_absent_zero;
    !FP_PRESENT |-> fp_pair_low_permission == 2'h0 && fp_pair_high_permission == 2'h0;
  endproperty
  a_absent_zero: assert property (p_absent_zero) else $error("absent field moved");

  property p_ns_read_zero;
    s_acc_req ##0 !req_write && req_privileged && req_nonsecure &&
      !nonsecure_access_gate[0] |=> resp_rdata[21:20] == 2'h0;
  endproperty
  a_ns_read_zero: assert property (p_ns_read_zero) else $error("gated field visible");

  property p_secure_write;
    s_acc_req ##0 req_write && req_privileged && !req_nonsecure && FP_PRESENT
      |=> fp_pair_high_permission == $past(req_wdata[23:22]);
  endproperty
  a_secure_write: assert property (p_secure_write) else $error("write lost");

  property p_fp_only_ones;
    s_acc_req ##0 !req_write && req_privileged && FP_ONLY |=> resp_rdata[31:30] == 2'h3;
  endproperty
  a_fp_only_ones: assert property (p_fp_only_ones) else $error("disable bits not one");

  property p_reserved_zero;
    resp_valid && !resp_undef |-> resp_rdata[29:24] == 6'h00 && resp_rdata[19:0] == 20'h0 ||
      resp_rdata[31:6] == 26'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  property p_sec_ns_undef;
    s_sec_req ##0 (req_nonsecure || !req_privileged)
      |=> resp_valid && resp_undef && resp_rdata == 32'h0000_0000;
  endproperty
  a_sec_ns_undef: assert property (p_sec_ns_undef) else $error("config access taken");

  property p_gate_wi;
    s_acc_req ##0 req_write && req_privileged && req_nonsecure &&
      !nonsecure_access_gate[0] |=> $stable(fp_pair_low_permission);
  endproperty
  a_gate_wi: assert property (p_gate_wi) else $error("gated field written");

  property p_simd_wr;
    s_acc_req ##0 req_write && req_privileged && !req_nonsecure &&
      BUILD == cpa_pkg::CPA_BUILD_FP_SIMD |=> simd_disable == $past(req_wdata[31]);
  endproperty
  a_simd_wr: assert property (p_simd_wr) else $error("simd disable not stored");

  property p_absent_read;
    s_acc_req ##0 !req_write && req_privileged && !FP_PRESENT |=> resp_rdata == 32'h0000_0000;
  endproperty
  a_absent_read: assert property (p_absent_read) else $error("absent build read nonzero");

  property p_sec_write;
    s_sec_req ##0 req_write && req_privileged && !req_nonsecure
      |=> secure_configuration == $past(req_wdata[5:0]);
  endproperty
  a_sec_write: assert property (p_sec_write) else $error("secure config write lost");

endmodule : cpa_regs

//--- testbench/cpa_pipe_model.sv
`timescale 1ns/10ps
module cpa_pipe_model (
  // clock
  input  wire logic        core_clk,
  // move request
  output logic             req_valid,
  output logic             req_write,
  output logic [2:0]       req_opc1,
  output logic [3:0]       req_crn,
  output logic [3:0]       req_crm,
  output logic [2:0]       req_opc2,
  output logic [31:0]      req_wdata,
  output logic             req_privileged,
  output logic             req_nonsecure,
  // instruction check
  output logic             ins_valid,
  output logic             ins_cp_high,
  output logic             ins_simd,
  output logic             ins_upper_dregs,
  output logic             ins_privileged,
  output logic             ins_nonsecure
);
  initial begin
    {req_valid, req_write, req_privileged, req_nonsecure} = 4'h0;
    {req_opc1, req_crn, req_crm, req_opc2} = 14'h0;
    req_wdata = 32'h0000_0000;
    {ins_valid, ins_cp_high, ins_simd, ins_upper_dregs} = 4'h0;
    {ins_privileged, ins_nonsecure} = 2'h0;
  end

  // ****************************************
  // move request, one pulse
  // ****************************************
  task automatic mv(input logic wr, input logic [3:0] crm, input logic [2:0] opc2,
                    input logic [31:0] wd, input logic priv, input logic ns);
    @(posedge core_clk);
    req_valid      <= 1'b1;
    req_write      <= wr;
    req_opc1       <= 3'h0;
    req_crn        <= 4'h1;
    req_crm        <= crm;
    req_opc2       <= opc2;
    req_wdata      <= wd;
    req_privileged <= priv;
    req_nonsecure  <= ns;
    @(posedge core_clk);
    req_valid      <= 1'b0;
    req_wdata      <= ~wd;
    #1;
  endtask : mv

  // ****************************************
  // instruction check, one pulse
  // ****************************************
  task automatic chk(input logic high, input logic simd, input logic upper,
                     input logic priv, input logic ns);
    @(posedge core_clk);
    @(posedge core_clk);
    ins_valid       <= 1'b1;
    ins_cp_high     <= high;
    ins_simd        <= simd;
    ins_upper_dregs <= upper;
    ins_privileged  <= priv;
    ins_nonsecure   <= ns;
    @(posedge core_clk);
    ins_valid       <= 1'b0;
    #1;
  endtask : chk
endmodule : cpa_pipe_model

//--- testbench/cpa_regs_bench.sv
`timescale 1ns/10ps
module cpa_regs_bench;
  // ****************************************
  // signals
  // ****************************************
  logic        core_clk = 1'b0;
  logic        rst      = 1'b1;
  logic [1:0]  gate     = 2'h0;
  logic        req_valid, req_write, req_privileged, req_nonsecure;
  logic [2:0]  req_opc1, req_opc2;
  logic [3:0]  req_crn, req_crm;
  logic [31:0] req_wdata;
  logic        ins_valid, ins_cp_high, ins_simd, ins_upper_dregs;
  logic        ins_privileged, ins_nonsecure;
  logic        rv [3], ru [3], id [3], iu [3], sd [3], ud [3];
  logic [31:0] rd [3];
  logic [1:0]  ph [3], pl [3];
  logic [5:0]  sc [3];
  int          n_mismatch = 0;
  int          tests_run  = 0;
  int          cycles     = 0;

  always #50 core_clk = ~core_clk;

  cpa_pipe_model model (
    .core_clk(core_clk), .req_valid(req_valid), .req_write(req_write),
    .req_opc1(req_opc1), .req_crn(req_crn), .req_crm(req_crm), .req_opc2(req_opc2),
    .req_wdata(req_wdata), .req_privileged(req_privileged), .req_nonsecure(req_nonsecure),
    .ins_valid(ins_valid), .ins_cp_high(ins_cp_high), .ins_simd(ins_simd),
    .ins_upper_dregs(ins_upper_dregs), .ins_privileged(ins_privileged),
    .ins_nonsecure(ins_nonsecure)
  );

  // ****************************************
  // one instance per build
  // ****************************************
  for (genvar g = 0; g < 3; g++) begin : gen_build
    cpa_regs #(.BUILD(cpa_pkg::cpa_build_e'(g))) dut (
      .core_clk(core_clk), .rst(rst), .req_valid(req_valid), .req_write(req_write),
      .req_opc1(req_opc1), .req_crn(req_crn), .req_crm(req_crm), .req_opc2(req_opc2),
      .req_wdata(req_wdata), .req_privileged(req_privileged),
      .req_nonsecure(req_nonsecure), .resp_valid(rv[g]), .resp_undef(ru[g]),
      .resp_rdata(rd[g]), .nonsecure_access_gate(gate), .ins_valid(ins_valid),
      .ins_cp_high(ins_cp_high), .ins_simd(ins_simd), .ins_upper_dregs(ins_upper_dregs),
      .ins_privileged(ins_privileged), .ins_nonsecure(ins_nonsecure),
      .ins_done(id[g]), .ins_undef(iu[g]), .simd_disable(sd[g]),
      .upper_dregs_disable(ud[g]), .fp_pair_high_permission(ph[g]),
      .fp_pair_low_permission(pl[g]), .secure_configuration(sc[g])
    );
  end

  // ****************************************
  // compare and report
  // ****************************************
  task automatic cmp_w(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t word got %h exp %h", $time, got, exp);
    end
  endtask : cmp_w

  task automatic cmp_b(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t flag got %b exp %b", $time, got, exp);
    end
  endtask : cmp_b

  task automatic end_of_test;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // read-back per build: full, float-only, none
  function automatic logic [31:0] exp_rd(input int g, input logic [31:0] w);
    if (g == 0) return w & 32'hc0f0_0000;
    if (g == 1) return (w & 32'h00f0_0000) | 32'hc000_0000;
    return 32'h0000_0000;
  endfunction : exp_rd

  task automatic wr(input logic [31:0] w);
    model.mv(1'b1, 4'h0, 3'h2, w, 1'b1, 1'b0);
  endtask : wr

  task automatic rdr(input logic ns);
    model.mv(1'b0, 4'h0, 3'h2, 32'h0000_0000, 1'b1, ns);
  endtask : rdr

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    for (int g = 0; g < 3; g++) begin
      cmp_w({28'h0, ph[g], pl[g]}, 32'h0);
      cmp_b(sd[g], g == 1);
      cmp_b(ud[g], g == 1);
      cmp_w({26'h0, sc[g]}, 32'h0);
      cmp_b(rv[g], 1'b0);
    end
  endtask : t_reset

  task automatic t_user;
    model.mv(1'b1, 4'h0, 3'h2, 32'hffff_ffff, 1'b0, 1'b0);
    for (int g = 0; g < 3; g++) begin
      cmp_b(rv[g], 1'b1);
      cmp_b(ru[g], 1'b1);
      cmp_w({28'h0, ph[g], pl[g]}, 32'h0);
    end
    model.mv(1'b0, 4'h0, 3'h2, 32'h0000_0000, 1'b0, 1'b1);
    for (int g = 0; g < 3; g++) cmp_b(ru[g], 1'b1);
  endtask : t_user

  task automatic t_rw;
    wr(32'hffff_ffff);
    for (int g = 0; g < 3; g++) cmp_b(ru[g], 1'b0);
    rdr(1'b0);
    for (int g = 0; g < 3; g++) cmp_w(rd[g], exp_rd(g, 32'hffff_ffff));
    model.mv(1'b0, 4'h0, 3'h3, 32'h0000_0000, 1'b1, 1'b0);
    for (int g = 0; g < 3; g++) cmp_b(rv[g], 1'b0);
    wr(32'h0000_0000);
    rdr(1'b0);
    for (int g = 0; g < 3; g++) cmp_w(rd[g], exp_rd(g, 32'h0000_0000));
  endtask : t_rw

  task automatic t_perm;
    for (int p = 0; p < 4; p++) begin
      wr({8'h0, p[1:0], p[1:0], 20'h0});
      model.chk(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
      cmp_b(id[0], 1'b1);
      cmp_b(iu[0], p == 0 || p == 2);
      model.chk(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      cmp_b(iu[0], p != 3);
    end
  endtask : t_perm

  task automatic t_gate;
    wr(32'h00f0_0000);
    rdr(1'b1);
    cmp_b(ru[0], 1'b0);
    cmp_w(rd[0], 32'h0000_0000);
    model.mv(1'b1, 4'h0, 3'h2, 32'h0000_0000, 1'b1, 1'b1);
    rdr(1'b0);
    cmp_w(rd[0], 32'h00f0_0000);
    model.chk(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    cmp_b(iu[0], 1'b1);
    @(posedge core_clk) gate <= 2'h3;
    model.mv(1'b1, 4'h0, 3'h2, 32'h0050_0000, 1'b1, 1'b1);
    rdr(1'b0);
    cmp_w(rd[0], 32'h0050_0000);
    model.chk(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    cmp_b(iu[0], 1'b0);
    model.chk(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    cmp_b(iu[0], 1'b1);
  endtask : t_gate

  task automatic t_dis;
    wr(32'h80f0_0000);
    cmp_b(sd[0], 1'b1);
    model.chk(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    cmp_b(iu[0], 1'b1);
    model.chk(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    cmp_b(iu[0], 1'b0);
    wr(32'h40f0_0000);
    cmp_b(ud[0], 1'b1);
    model.chk(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    cmp_b(iu[0], 1'b0);
    model.chk(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    cmp_b(iu[0], 1'b1);
    model.chk(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    cmp_b(iu[0], 1'b0);
  endtask : t_dis

  task automatic t_sec;
    model.mv(1'b1, 4'h1, 3'h0, 32'hffff_ffff, 1'b1, 1'b0);
    for (int g = 0; g < 3; g++) cmp_w({26'h0, sc[g]}, 32'h0000_003f);
    model.mv(1'b1, 4'h1, 3'h0, 32'h0000_0000, 1'b1, 1'b1);
    for (int g = 0; g < 3; g++) cmp_b(ru[g], 1'b1);
    model.mv(1'b0, 4'h1, 3'h0, 32'h0000_0000, 1'b0, 1'b0);
    for (int g = 0; g < 3; g++) cmp_b(ru[g], 1'b1);
    model.mv(1'b0, 4'h1, 3'h0, 32'h0000_0000, 1'b1, 1'b0);
    for (int g = 0; g < 3; g++) cmp_w(rd[g], 32'h0000_003f);
  endtask : t_sec

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    t_reset();
    t_user();
    t_rw();
    t_perm();
    t_gate();
    t_dis();
    t_sec();
    end_of_test();
  end
endmodule : cpa_regs_bench
